// ---- hdl/usbr_vendor_regs.v ----
// Vendor control request decoder and register bank of a two-channel serial bridge
//
// Behaviour
// R1 - A write (type 0x40, code 0) puts value[7:0] at register index[7:0] of block index[15:8].
// R2 - A read (type 0xC0, code 1) returns as many bytes as the length field asks.
// R3 - A class request (type 0x21, code 35) breaks the indexed channel for value milliseconds; value 0xFFFF holds the break until the next such request.
// R4 - Block 0 selects the first channel's registers.
// R5 - Block 1 selects the second channel's registers.
// R6 - Block 4 selects the manager with per-channel queue enables and flushes.
// R7 - Block 0x66 selects wide mode, low latency and interrupt packet enables.
// R8 - Registers are reached only through these vendor requests.
// R9 - Bring-up writes queue enable 1, then channel enable 3, then queue enable 3.
// R10 - A non-zero write to a flush register empties that queue; a zero write does nothing.
// R11 - A channel block controls all but the three enables of the custom block; the queue enables and flushes are in manager block 4 instead.
// R12 - Channel enable bit 0 turns on transmit and bit 1 turns on receive.
// R13 - Baud timing uses a 19-bit divisor in three registers and two 16-bit fraction masks.
// R14 - With handshake bit 3 set, receive input is ignored while the channel transmits.
// R15 - A multi-byte read walks consecutive addresses from the given one in the block.
// R16 - Reserved locations and bits read zero and ignore writes.
`default_nettype none
`include "usbr_map.vh"
module usbr_vendor_regs #(
  parameter integer MS_CYCLES = `USBR_MS_NS / `USBR_CLK_NS
) (
  input  wire        clk,            // System clock, 40 MHz
  input  wire        rst_n,          // Synchronous reset, active low
  input  wire        setupValid,     // Setup packet present, one cycle
  input  wire [7:0]  reqType,        // Request type byte
  input  wire [7:0]  reqCode,        // Request code byte
  input  wire [15:0] reqValue,       // Value field
  input  wire [15:0] reqIndex,       // Index field
  input  wire [15:0] reqLength,      // Length field
  output reg         setupAck_q,     // Request accepted, pulse
  output reg         setupStall_q,   // Request refused, pulse
  output reg         rdValid_q,      // Data stage byte valid
  output reg  [7:0]  rdData_q,       // Data stage byte
  output reg         rdLast_q,       // Final byte of the data stage
  input  wire        rdReady,        // Endpoint takes the byte
  input  wire [9:0]  lineErrors,     // Error flags, B in [9:5]
  input  wire [1:0]  txBusy,         // Transmitters shifting
  input  wire [11:0] pinIn,          // Pin levels, B in [11:6]
  output wire [1:0]  txEnable,       // Transmit enables
  output wire [1:0]  rxEnable,       // Receive enables
  output wire [37:0] baudDiv,        // Divisors, B in [37:19]
  output wire [31:0] txFracMask,     // Transmit masks, B high
  output wire [31:0] rxFracMask,     // Receive masks, B high
  output wire [15:0] frameFormat,    // Frame formats, B high
  output wire [7:0]  flowSelect,     // Handshake selects, B high
  output wire [15:0] resumeChar,     // Resume characters
  output wire [15:0] pauseChar,      // Pause characters
  output wire [7:0]  turnDelay,      // Turnaround delays
  output wire [7:0]  pinMode,        // Pin function selects
  output wire [11:0] pinDir,         // Pin directions
  output wire [11:0] pinEventMask,   // Pin event masks
  output wire [11:0] pinOut,         // Pin output latches
  output wire [1:0]  rxSuppress,     // Receive input ignored
  output reg  [1:0]  breakOut_q,     // Break driven on the line
  output wire [1:0]  txQueueEn,      // Transmit queue enables
  output wire [1:0]  rxQueueEn,      // Receive queue enables
  output reg  [1:0]  txQueueFlush_q, // Transmit queue flush, pulse
  output reg  [1:0]  rxQueueFlush_q, // Receive queue flush, pulse
  output reg  [1:0]  wideMode_q,     // Wide mode enables
  output reg  [1:0]  lowLatency_q,   // Low latency enables
  output reg  [1:0]  intPacket_q     // Custom interrupt packet enables
);

  // ------------------------------
  // Request decode
  // ------------------------------
  wire       isWrite;
  wire       isRead;
  wire       isBreak;
  wire [7:0] wrBlock;
  wire [7:0] wrAddr;
  wire [7:0] wrData;

  // Only these three requests reach the registers or the line
  assign isWrite = setupValid && reqType == `USBR_TYPE_VWR && reqCode == `USBR_CODE_VWR; // R1 R8
  assign isRead  = setupValid && reqType == `USBR_TYPE_VRD && reqCode == `USBR_CODE_VRD; // R2 R8
  assign isBreak = setupValid && reqType == `USBR_TYPE_CLASS && reqCode == `USBR_CODE_BREAK; // R3
  assign wrBlock = reqIndex[15:8]; // R1
  assign wrAddr  = reqIndex[7:0]; // R1
  assign wrData  = reqValue[7:0]; // R1

  // Acknowledge known requests, refuse anything else
  always @(posedge clk) begin
    if (!rst_n) begin
      setupAck_q   <= 1'b0;
      setupStall_q <= 1'b0;
    end else begin
      setupAck_q   <= isWrite | isRead | isBreak;
      setupStall_q <= setupValid & ~(isWrite | isRead | isBreak); // R8
    end
  end

  // ------------------------------
  // Channel blocks
  // ------------------------------
  reg  [7:0]  rdBlock_q;
  reg  [7:0]  rdAddr_q;
  wire [15:0] chanRead;
  wire [15:0] breakRegs;
  wire [1:0]  breakTimed;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire chanWrite;
      assign chanWrite = isWrite && wrBlock == ch; // R4 R5 R11

      usbr_chan_regs uRegs (
        .clk          (clk),
        .rst_n        (rst_n),
        .wrEn         (chanWrite),
        .wrAddr       (wrAddr),
        .wrData       (wrData),
        .rdAddr       (rdAddr_q),
        .rdData       (chanRead[8*ch +: 8]),
        .lineErrors   (lineErrors[5*ch +: 5]),
        .txBusy       (txBusy[ch]),
        .pinIn        (pinIn[6*ch +: 6]),
        .enable_q     ({rxEnable[ch], txEnable[ch]}),
        .divisor_q    (baudDiv[19*ch +: 19]),
        .txMask_q     (txFracMask[16*ch +: 16]),
        .rxMask_q     (rxFracMask[16*ch +: 16]),
        .format_q     (frameFormat[8*ch +: 8]),
        .flow_q       (flowSelect[4*ch +: 4]),
        .resume_q     (resumeChar[8*ch +: 8]),
        .pause_q      (pauseChar[8*ch +: 8]),
        .breakReg_q   (breakRegs[8*ch +: 8]),
        .turn_q       (turnDelay[4*ch +: 4]),
        .pinMode_q    (pinMode[4*ch +: 4]),
        .pinDir_q     (pinDir[6*ch +: 6]),
        .pinMask_q    (pinEventMask[6*ch +: 6]),
        .pinOut_q     (pinOut[6*ch +: 6]),
        .rxSuppress_q (rxSuppress[ch])
      );

      usbr_break_gen #(
        .MS_CYCLES (MS_CYCLES)
      ) uBreak (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (isBreak && reqIndex[7:0] == (ch == 0 ? `USBR_IFC_CHA : `USBR_IFC_CHB)), // R3
        .duration (reqValue),
        .active_q (breakTimed[ch])
      );
    end
  endgenerate

  // Line break from the class request or the break register
  always @(posedge clk) begin
    if (!rst_n)
      breakOut_q <= 2'h0;
    else
      breakOut_q <= breakTimed | {breakRegs[15:8] != 8'h00, breakRegs[7:0] != 8'h00}; // R3
  end

  // ------------------------------
  // Manager block
  // ------------------------------
  reg  [1:0] queueEnA_q;
  reg  [1:0] queueEnB_q;
  wire       mgrWrite;
  wire       nonZero;

  assign mgrWrite  = isWrite && wrBlock == `USBR_BLK_MGR; // R6
  assign nonZero   = wrData != 8'h00;
  assign txQueueEn = {queueEnB_q[0], queueEnA_q[0]};
  assign rxQueueEn = {queueEnB_q[1], queueEnA_q[1]};

  // Enables held; the host sequences them with the channel enable
  always @(posedge clk) begin
    if (!rst_n) begin
      queueEnA_q <= 2'h0;
      queueEnB_q <= 2'h0;
    end else if (mgrWrite) begin
      if (wrAddr == `USBR_MG_QEN_A)
        queueEnA_q <= wrData[1:0]; // R6
      if (wrAddr == `USBR_MG_QEN_B)
        queueEnB_q <= wrData[1:0]; // R6
    end
  end

  // Flush strobes last one cycle; zero data leaves the queues alone
  always @(posedge clk) begin
    if (!rst_n) begin
      txQueueFlush_q <= 2'h0;
      rxQueueFlush_q <= 2'h0;
    end else begin
      rxQueueFlush_q[0] <= mgrWrite && nonZero && wrAddr == `USBR_MG_RXFL_A; // R10
      rxQueueFlush_q[1] <= mgrWrite && nonZero && wrAddr == `USBR_MG_RXFL_B; // R10
      txQueueFlush_q[0] <= mgrWrite && nonZero && wrAddr == `USBR_MG_TXFL_A; // R10
      txQueueFlush_q[1] <= mgrWrite && nonZero && wrAddr == `USBR_MG_TXFL_B; // R10
    end
  end

  // ------------------------------
  // Custom block
  // ------------------------------
  wire cusWrite;
  assign cusWrite = isWrite && wrBlock == `USBR_BLK_CUS; // R7

  // One bit per channel in each enable register
  always @(posedge clk) begin
    if (!rst_n) begin
      wideMode_q   <= 2'h0;
      lowLatency_q <= 2'h0;
      intPacket_q  <= 2'h0;
    end else if (cusWrite) begin
      if (wrAddr == `USBR_CU_WIDE)
        wideMode_q <= wrData[1:0]; // R7 R11
      if (wrAddr == `USBR_CU_LOWLAT)
        lowLatency_q <= wrData[1:0]; // R7 R11
      if (wrAddr == `USBR_CU_INTPKT)
        intPacket_q <= wrData[1:0]; // R7 R11
    end
  end

  // ------------------------------
  // Readback selection
  // ------------------------------
  // Flush registers are write-only and read zero like reserved space
  function [7:0] readByte;
    input [7:0]  blk;
    input [7:0]  addr;
    input [15:0] chan;
    begin
      readByte = 8'h00; // R16
      if (blk == `USBR_BLK_CHA)
        readByte = chan[7:0]; // R4
      else if (blk == `USBR_BLK_CHB)
        readByte = chan[15:8]; // R5
      else if (blk == `USBR_BLK_MGR && addr == `USBR_MG_QEN_A)
        readByte = {6'h00, queueEnA_q}; // R6
      else if (blk == `USBR_BLK_MGR && addr == `USBR_MG_QEN_B)
        readByte = {6'h00, queueEnB_q}; // R6
      else if (blk == `USBR_BLK_CUS && addr == `USBR_CU_WIDE)
        readByte = {6'h00, wideMode_q}; // R7
      else if (blk == `USBR_BLK_CUS && addr == `USBR_CU_LOWLAT)
        readByte = {6'h00, lowLatency_q}; // R7
      else if (blk == `USBR_BLK_CUS && addr == `USBR_CU_INTPKT)
        readByte = {6'h00, intPacket_q}; // R7
    end
  endfunction

  // ------------------------------
  // Data stage streamer
  // ------------------------------
  localparam [0:0] ST_IDLE   = 1'b0;
  localparam [0:0] ST_STREAM = 1'b1;

  reg  [0:0]  state_q;
  reg  [15:0] remain_q;
  wire        loadNext;

  // A byte is fetched when the output slot is free or being taken
  assign loadNext = state_q == ST_STREAM && remain_q != 16'h0000 && (!rdValid_q || rdReady);

  // Any new setup packet cancels an unfinished data stage
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      remain_q  <= 16'h0000;
      rdBlock_q <= 8'h00;
      rdAddr_q  <= 8'h00;
      rdValid_q <= 1'b0;
      rdData_q  <= 8'h00;
      rdLast_q  <= 1'b0;
    end else if (setupValid) begin
      state_q   <= isRead && reqLength != 16'h0000 ? ST_STREAM : ST_IDLE; // R2
      remain_q  <= isRead ? reqLength : 16'h0000; // R2
      rdBlock_q <= reqIndex[15:8]; // R15
      rdAddr_q  <= reqIndex[7:0]; // R15
      rdValid_q <= 1'b0;
      rdLast_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_STREAM: begin
          if (loadNext) begin
            rdData_q  <= readByte(rdBlock_q, rdAddr_q, chanRead); // R15
            rdValid_q <= 1'b1;
            rdLast_q  <= remain_q == 16'h0001;
            rdAddr_q  <= rdAddr_q + 8'h01; // R15
            remain_q  <= remain_q - 16'h0001; // R2
          end else if (rdValid_q && rdReady) begin
            rdValid_q <= 1'b0;
            rdLast_q  <= 1'b0;
            state_q   <= ST_IDLE;
          end
        end
        default: begin
          rdValid_q <= 1'b0;
          rdLast_q  <= 1'b0;
        end
      endcase
    end
  end
endmodule // usbr_vendor_regs
`default_nettype wire

// ---- hdl/usbr_map.vh ----
// Offsets, request codes, field positions and timing counts of the vendor register bank
`ifndef USBR_MAP_VH
`define USBR_MAP_VH

// ------------------------------
// Control request codes
// ------------------------------
`define USBR_TYPE_VWR      8'h40
`define USBR_CODE_VWR      8'h00
`define USBR_TYPE_VRD      8'hC0
`define USBR_CODE_VRD      8'h01
`define USBR_TYPE_CLASS    8'h21
`define USBR_CODE_BREAK    8'h23
`define USBR_IFC_CHA       8'h00
`define USBR_IFC_CHB       8'h02

// ------------------------------
// Block numbers
// ------------------------------
`define USBR_BLK_CHA       8'h00
`define USBR_BLK_CHB       8'h01
`define USBR_BLK_MGR       8'h04
`define USBR_BLK_CUS       8'h66

// ------------------------------
// Per-channel register offsets
// ------------------------------
`define USBR_CH_ENABLE     8'h03
`define USBR_CH_DIV0       8'h04
`define USBR_CH_DIV1       8'h05
`define USBR_CH_DIV2       8'h06
`define USBR_CH_TXM0       8'h07
`define USBR_CH_TXM1       8'h08
`define USBR_CH_RXM0       8'h09
`define USBR_CH_RXM1       8'h0A
`define USBR_CH_FORMAT     8'h0B
`define USBR_CH_FLOW       8'h0C
`define USBR_CH_RESUME     8'h10
`define USBR_CH_PAUSE      8'h11
`define USBR_CH_ERRORS     8'h13
`define USBR_CH_BREAK      8'h14
`define USBR_CH_TURN       8'h15
`define USBR_CH_PMODE      8'h1A
`define USBR_CH_PDIR       8'h1B
`define USBR_CH_PMASK      8'h1C
`define USBR_CH_PSET       8'h1D
`define USBR_CH_PCLR       8'h1E
`define USBR_CH_PLEVEL     8'h1F

// ------------------------------
// Manager and custom block offsets
// ------------------------------
`define USBR_MG_QEN_A      8'h10
`define USBR_MG_QEN_B      8'h11
`define USBR_MG_RXFL_A     8'h18
`define USBR_MG_RXFL_B     8'h19
`define USBR_MG_TXFL_A     8'h1C
`define USBR_MG_TXFL_B     8'h1D
`define USBR_CU_WIDE       8'h00
`define USBR_CU_LOWLAT     8'h01
`define USBR_CU_INTPKT     8'h02

// ------------------------------
// Fields, reset values, timing
// ------------------------------
`define USBR_FLOW_HDX      3
`define USBR_RST_BYTE      8'h00
`define USBR_BREAK_FOREVER 16'hFFFF
`define USBR_MS_NS         32'h000F_4240
`define USBR_CLK_NS        32'h0000_0019

`endif

// ---- hdl/usbr_break_gen.v ----
// Break duration timer for one channel, counting whole milliseconds
`default_nettype none
module usbr_break_gen #(
  parameter integer MS_CYCLES = 40000
) (
  input  wire        clk,       // System clock
  input  wire        rst_n,     // Synchronous reset, active low
  input  wire        start,     // Break request pulse
  input  wire [15:0] duration,  // Length in milliseconds
  output reg         active_q   // Break being driven
);
  `include "usbr_map.vh"

  reg [31:0] tickCnt_q;
  reg [15:0] msLeft_q;
  reg        forever_q;

  // A new request restarts the timer; zero ends any break at once
  always @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_q <= 32'h0000_0000;
      msLeft_q  <= 16'h0000;
      forever_q <= 1'b0;
      active_q  <= 1'b0;
    end else if (start) begin
      tickCnt_q <= 32'h0000_0000;
      msLeft_q  <= duration;
      forever_q <= (duration == `USBR_BREAK_FOREVER);
      active_q  <= (duration != 16'h0000);
    end else if (active_q && !forever_q) begin
      if (tickCnt_q == MS_CYCLES - 1) begin
        tickCnt_q <= 32'h0000_0000;
        msLeft_q  <= msLeft_q - 16'h0001;
        if (msLeft_q == 16'h0001)
          active_q <= 1'b0;
      end else begin
        tickCnt_q <= tickCnt_q + 32'h0000_0001;
      end
    end
  end
endmodule // usbr_break_gen
`default_nettype wire

// ---- hdl/usbr_chan_regs.v ----
// Configuration and control register block of one serial channel
`default_nettype none
module usbr_chan_regs (
  input  wire        clk,          // System clock
  input  wire        rst_n,        // Synchronous reset, active low
  input  wire        wrEn,         // Write strobe for this block
  input  wire [7:0]  wrAddr,       // Write register address
  input  wire [7:0]  wrData,       // Write data
  input  wire [7:0]  rdAddr,       // Read register address
  output reg  [7:0]  rdData,       // Read data, combinational
  input  wire [4:0]  lineErrors,   // Error flags from the receiver
  input  wire        txBusy,       // Transmitter shifting
  input  wire [5:0]  pinIn,        // Pin levels, asynchronous
  output reg  [1:0]  enable_q,     // Bit 0 transmit, bit 1 receive
  output reg  [18:0] divisor_q,    // Baud divisor
  output reg  [15:0] txMask_q,     // Transmit fraction mask
  output reg  [15:0] rxMask_q,     // Receive fraction mask
  output reg  [7:0]  format_q,     // Frame format
  output reg  [3:0]  flow_q,       // Handshake select
  output reg  [7:0]  resume_q,     // Resume character
  output reg  [7:0]  pause_q,      // Pause character
  output reg  [7:0]  breakReg_q,   // Software break register
  output reg  [3:0]  turn_q,       // Driver turnaround delay
  output reg  [3:0]  pinMode_q,    // Pin function select
  output reg  [5:0]  pinDir_q,     // Pin direction
  output reg  [5:0]  pinMask_q,    // Pin event mask
  output reg  [5:0]  pinOut_q,     // Pin output latch
  output reg         rxSuppress_q  // Receive input ignored
);
  `include "usbr_map.vh"

  reg [5:0] pinMeta_q;
  reg [5:0] pinSync_q;

  // Two stages before anyone looks at the pins
  always @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_q <= 6'h00;
      pinSync_q <= 6'h00;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // Register writes; reserved bits are dropped
  always @(posedge clk) begin
    if (!rst_n) begin
      enable_q   <= 2'h0;
      divisor_q  <= 19'h0_0000;
      txMask_q   <= 16'h0000;
      rxMask_q   <= 16'h0000;
      format_q   <= `USBR_RST_BYTE;
      flow_q     <= 4'h0;
      resume_q   <= `USBR_RST_BYTE;
      pause_q    <= `USBR_RST_BYTE;
      breakReg_q <= `USBR_RST_BYTE;
      turn_q     <= 4'h0;
      pinMode_q  <= 4'h0;
      pinDir_q   <= 6'h00;
      pinMask_q  <= 6'h00;
      pinOut_q   <= 6'h00;
    end else if (wrEn) begin
      case (wrAddr)
        `USBR_CH_ENABLE: enable_q <= wrData[1:0]; // R12
        `USBR_CH_DIV0:   divisor_q[7:0] <= wrData; // R13
        `USBR_CH_DIV1:   divisor_q[15:8] <= wrData; // R13
        `USBR_CH_DIV2:   divisor_q[18:16] <= wrData[2:0]; // R13
        `USBR_CH_TXM0:   txMask_q[7:0] <= wrData; // R13
        `USBR_CH_TXM1:   txMask_q[15:8] <= wrData; // R13
        `USBR_CH_RXM0:   rxMask_q[7:0] <= wrData; // R13
        `USBR_CH_RXM1:   rxMask_q[15:8] <= wrData; // R13
        `USBR_CH_FORMAT: format_q <= wrData;
        `USBR_CH_FLOW:   flow_q <= wrData[3:0];
        `USBR_CH_RESUME: resume_q <= wrData;
        `USBR_CH_PAUSE:  pause_q <= wrData;
        `USBR_CH_BREAK:  breakReg_q <= wrData;
        `USBR_CH_TURN:   turn_q <= wrData[3:0];
        `USBR_CH_PMODE:  pinMode_q <= wrData[3:0];
        `USBR_CH_PDIR:   pinDir_q <= wrData[5:0];
        `USBR_CH_PMASK:  pinMask_q <= wrData[5:0];
        `USBR_CH_PSET:   pinOut_q <= pinOut_q | wrData[5:0];
        `USBR_CH_PCLR:   pinOut_q <= pinOut_q & ~wrData[5:0];
        default:         pinOut_q <= pinOut_q; // R16
      endcase
    end
  end

  // Half-duplex: receive blanked while the transmitter shifts
  always @(posedge clk) begin
    if (!rst_n)
      rxSuppress_q <= 1'b0;
    else
      rxSuppress_q <= flow_q[`USBR_FLOW_HDX] & txBusy; // R14
  end

  // Readback; reserved locations and bits give zero
  always @* begin
    case (rdAddr)
      `USBR_CH_ENABLE: rdData = {6'h00, enable_q};
      `USBR_CH_DIV0:   rdData = divisor_q[7:0];
      `USBR_CH_DIV1:   rdData = divisor_q[15:8];
      `USBR_CH_DIV2:   rdData = {5'h00, divisor_q[18:16]};
      `USBR_CH_TXM0:   rdData = txMask_q[7:0];
      `USBR_CH_TXM1:   rdData = txMask_q[15:8];
      `USBR_CH_RXM0:   rdData = rxMask_q[7:0];
      `USBR_CH_RXM1:   rdData = rxMask_q[15:8];
      `USBR_CH_FORMAT: rdData = format_q;
      `USBR_CH_FLOW:   rdData = {4'h0, flow_q};
      `USBR_CH_RESUME: rdData = resume_q;
      `USBR_CH_PAUSE:  rdData = pause_q;
      `USBR_CH_ERRORS: rdData = {lineErrors, 3'h0};
      `USBR_CH_BREAK:  rdData = breakReg_q;
      `USBR_CH_TURN:   rdData = {4'h0, turn_q};
      `USBR_CH_PMODE:  rdData = {4'h0, pinMode_q};
      `USBR_CH_PDIR:   rdData = {2'h0, pinDir_q};
      `USBR_CH_PMASK:  rdData = {2'h0, pinMask_q};
      `USBR_CH_PSET:   rdData = {2'h0, pinOut_q};
      `USBR_CH_PCLR:   rdData = {2'h0, pinOut_q};
      `USBR_CH_PLEVEL: rdData = {2'h0, pinSync_q};
      default:         rdData = 8'h00; // R16
    endcase
  end
endmodule // usbr_chan_regs
`default_nettype wire

// ---- testbench/usbr_host_model.sv ----
// Host endpoint model that takes data-stage bytes, promptly or with stalls
`default_nettype none
module usbr_host_model (
  input  wire logic       clk,     // System clock
  input  wire logic       rdValid, // Byte offered
  input  wire logic [7:0] rdData,  // Byte value
  input  wire logic       rdLast,  // Final byte flag
  input  wire logic       slow,    // Stall every other cycle
  output var  logic       rdReady  // Byte taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [8];
  int         cnt = 0;
  int         lastAt = 0;
  // Slow mode toggles ready so the device has to hold its byte
  initial rdReady = 1'b0;
  always @(posedge clk) begin
    if (rdValid && rdReady && cnt < 8) begin
      got[cnt] = rdData;
      cnt = cnt + 1;
      if (rdLast) lastAt = (lastAt == 0) ? cnt : 99;
    end
    #1 rdReady = slow ? ~rdReady : 1'b1;
  end
endmodule // usbr_host_model
`default_nettype wire

// ---- testbench/usbr_vendor_regs_chk.sv ----
// Protocol checker for the vendor register bank
`default_nettype none
module usbr_vendor_regs_chk (
  input wire logic        clk, rst_n, setupValid, setupAck_q, setupStall_q, // Handshake
  input wire logic        rdValid_q, rdReady,                          // Data stage
  input wire logic [7:0]  reqType, reqCode, rdData_q,                  // Bytes
  input wire logic [15:0] reqValue, reqIndex, reqLength,               // Fields
  input wire logic [1:0]  txQueueFlush_q, rxQueueFlush_q               // Flushes
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic isWr, isRd, known;
  // Request decode, kept apart from the design's own
  assign isWr = setupValid && reqType == 8'h40 && reqCode == 8'h00;
  assign isRd = setupValid && reqType == 8'hC0 && reqCode == 8'h01;
  assign known = isWr || isRd || (setupValid && reqType == 8'h21 && reqCode == 8'h23);
  sequence s_rdReq; isRd && reqLength != 16'h0000; endsequence
  sequence s_first; setupAck_q ##1 rdValid_q; endsequence
  property p_ack; known |=> setupAck_q && !setupStall_q; endproperty
  property p_stall; setupValid && !known |=> setupStall_q && !setupAck_q; endproperty
  property p_quiet; !setupValid |=> !setupAck_q && !setupStall_q; endproperty
  property p_first; s_rdReq |=> s_first; endproperty
  property p_hold; rdValid_q && !rdReady && !setupValid |=> rdValid_q && $stable(rdData_q);
  endproperty
  property p_txfl; isWr && reqIndex == 16'h041C && reqValue[7:0] != 0 |=> txQueueFlush_q[0];
  endproperty
  property p_rxfl; isWr && reqIndex == 16'h0418 && reqValue[7:0] != 0 |=> rxQueueFlush_q[0];
  endproperty
  property p_rxzero; isWr && reqIndex[15:1] == 15'h020C && reqValue[7:0] == 0
    |=> rxQueueFlush_q == 2'b00; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  a_stall: assert property (p_stall) else $error("unknown request not stalled");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_first: assert property (p_first) else $error("first read byte late");
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  a_txfl: assert property (p_txfl) else $error("tx flush missing");
  a_rxfl: assert property (p_rxfl) else $error("rx flush missing");
  a_rxzero: assert property (p_rxzero) else $error("zero write flushed");
endmodule // usbr_vendor_regs_chk
bind usbr_vendor_regs usbr_vendor_regs_chk u_chk (.clk, .rst_n, .setupValid, .setupAck_q,
  .setupStall_q, .rdValid_q, .rdReady, .reqType, .reqCode, .rdData_q, .reqValue, .reqIndex,
  .reqLength, .txQueueFlush_q, .rxQueueFlush_q);
`default_nettype wire

// ---- testbench/test_usb_vendor_register_access.sv ----
// Self-checking bench for the vendor register bank
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module test_usb_vendor_register_access;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, setupValid = 0, slow = 0;
  logic [1:0] txBusy = 2'b00;
  logic [7:0] reqType = 0, reqCode = 0;
  logic [15:0] reqValue = 0, reqIndex = 0, reqLength = 0;
  wire logic setupAck_q, setupStall_q, rdValid_q, rdReady, rdLast_q;
  wire logic [7:0] rdData_q;
  wire logic [1:0] txEnable, rxEnable, breakOut_q, txQueueEn, txQueueFlush_q, rxQueueFlush_q;
  wire logic [1:0] wideMode_q, lowLatency_q, intPacket_q, rxSuppress;
  wire logic [37:0] baudDiv;
  int errors = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  usbr_vendor_regs #(.MS_CYCLES(4)) dut (.clk, .rst_n, .setupValid, .reqType, .reqCode,
    .reqValue, .reqIndex, .reqLength, .setupAck_q, .setupStall_q, .rdValid_q, .rdData_q,
    .rdLast_q, .rdReady, .lineErrors(10'h000), .txBusy, .pinIn(12'h000), .txEnable,
    .rxEnable, .baudDiv, .txFracMask(), .rxFracMask(), .frameFormat(), .flowSelect(),
    .resumeChar(), .pauseChar(), .turnDelay(), .pinMode(), .pinDir(), .pinEventMask(),
    .pinOut(), .rxSuppress, .breakOut_q, .txQueueEn, .rxQueueEn(), .txQueueFlush_q,
    .rxQueueFlush_q, .wideMode_q, .lowLatency_q, .intPacket_q);
  usbr_host_model host (.clk, .rdValid(rdValid_q), .rdData(rdData_q), .rdLast(rdLast_q), .slow,
    .rdReady);
  // One setup cycle; returns one ns after the answer edge
  task automatic put(input logic [7:0] t, c, input logic [15:0] v, i, l);
    @(posedge clk) #1;
    {setupValid, reqType, reqCode, reqValue, reqIndex, reqLength} = {1'b1, t, c, v, i, l};
    @(posedge clk) #1;
    setupValid = 0;
  endtask
  task automatic wr(input logic [7:0] b, r, v);
    put(8'h40, 8'h00, {8'h00, v}, {b, r}, 16'h0000);
  endtask
  task automatic rd(input logic [7:0] b, r, input int n);
    host.cnt = 0;
    host.lastAt = 0;
    put(8'hC0, 8'h01, 16'h0000, {b, r}, n[15:0]);
    repeat (2 * n + 4) @(posedge clk);
    `CHK("count", n, host.cnt)
    `CHK("last", n, host.lastAt)
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_chan();
    wr(8'h04, 8'h10, 8'h01);
    wr(8'h00, 8'h03, 8'h03);
    `CHK("ack", 1'b1, setupAck_q)
    `CHK("enA", 2'b11, {rxEnable[0], txEnable[0]})
    wr(8'h04, 8'h10, 8'h03);
    wr(8'h01, 8'h06, 8'hFF);
    `CHK("divB", 19'h7_0000, baudDiv[37:19])
    `CHK("divA", 19'h0_0000, baudDiv[18:0])
    rd(8'h00, 8'h03, 2);
    `CHK("enRead", 8'h03, host.got[0])
    `CHK("divRead", 8'h00, host.got[1])
    $display("chan done");
  endtask
  task automatic t_mgr();
    wr(8'h04, 8'h1C, 8'h80);
    `CHK("txFlush", 2'b01, txQueueFlush_q)
    wr(8'h04, 8'h18, 8'h01);
    `CHK("rxFlush", 2'b01, rxQueueFlush_q)
    wr(8'h04, 8'h19, 8'h00);
    `CHK("noFlush", 2'b00, rxQueueFlush_q)
    wr(8'h04, 8'h10, 8'h01);
    `CHK("qEn", 2'b01, txQueueEn)
    $display("mgr done");
  endtask
  task automatic t_cus();
    for (int i = 0; i < 3; i++) wr(8'h66, i[7:0], 8'h02);
    `CHK("custom", 6'h2A, {wideMode_q, lowLatency_q, intPacket_q})
    $display("custom done");
  endtask
  task automatic t_odd();
    put(8'h41, 8'h00, 16'h0000, 16'h0003, 16'h0000);
    `CHK("stall", 1'b1, setupStall_q)
    `CHK("enKept", 2'b11, {rxEnable[0], txEnable[0]})
    wr(8'h00, 8'h0C, 8'hFF);
    wr(8'h00, 8'h0D, 8'hFF);
    txBusy = 2'b01;
    @(posedge clk) #1;
    `CHK("suppress", 2'b01, rxSuppress)
    txBusy = 2'b00;
    slow = 1;
    rd(8'h00, 8'h0B, 3);
    `CHK("flow", 8'h0F, host.got[1])
    `CHK("resv", 8'h00, host.got[2])
    slow = 0;
    $display("odd done");
  endtask
  task automatic t_brk();
    put(8'h21, 8'h23, 16'h0002, 16'h0000, 16'h0000);
    @(posedge clk) #1;
    `CHK("brkOn", 2'b01, breakOut_q)
    repeat (12) @(posedge clk);
    `CHK("brkOff", 2'b00, breakOut_q)
    $display("break done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    t_chan();
    t_mgr();
    t_cus();
    t_odd();
    t_brk();
    give_verdict();
  end
  // Tests take some 75 cycles
  initial begin
    #(2000 * 25);
    errors++;
    give_verdict();
  end
endmodule // test_usb_vendor_register_access
`default_nettype wire
